/* File: hdl/spm_cfg.svh */
// Constants for the segment page mapper
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
// =====================================================
// Address layout
`define SPM_PAGE_BYTES 512
`define SPM_SEG_BYTES 131072
`define SPM_NUM_SEGS 128
`define SPM_NUM_CTX 4
`define SPM_RAM_WORDS 1024
`define SPM_RAM_AW 10
`define SPM_RAM_DW 12
`define SPM_SEG_HI 23
`define SPM_SEG_LO 17
`define SPM_PAGE_HI 16
`define SPM_PAGE_LO 9
// =====================================================
// Register access decode
`define SPM_MMU_SEL_BIT 15
`define SPM_MMU_NSEL_BIT 16
`define SPM_PAIR_SEL_BIT 3
`define SPM_SUPV_CTX 2'h0
`define SPM_CTX_RST 2'h0
`define SPM_PAGE_RST 12'h000
`define SPM_DATA_RST 12'h000
`define SPM_TYPE_RST 4'h0
`define SPM_PAGE_PAD 4'h0
// =====================================================
// Limit register fields and space codes
`define SPM_SIZE_HI 7
`define SPM_TYPE_HI 11
`define SPM_TYPE_LO 8
`define SPM_CARRY_BIT 8
`define SPM_CODE_MAIN 4'h0
`define SPM_CODE_IO 4'h1
`define SPM_CODE_SPIO 4'h2
`endif

/* File: hdl/spm_pkg.sv */
// Types shared by the segment page mapper
package spm_pkg;
	typedef logic [1:0] spm_ctx_t;
	typedef struct packed {
		logic [6:0] seg;
		logic [7:0] page;
		logic [7:0] off;
	} spm_laddr_s;
	typedef struct packed {
		logic [3:0] kind;
		logic [7:0] size;
	} spm_limit_s;
	typedef struct packed {
		logic limit_sel;
		spm_ctx_t ctx;
		logic [6:0] seg;
	} spm_ram_addr_s;
	typedef enum logic [1:0] {
		SPM_PH_ORIGIN = 2'b01,
		SPM_PH_LIMIT = 2'b10
	} spm_phase_e;
endpackage

/* File: hdl/spm_map_ram.sv */
// Flip-flop store of the mapping registers
`timescale 1ns/10ps
`default_nettype none
`include "spm_cfg.svh"
module spm_map_ram #(
	parameter int AW = `SPM_RAM_AW,
	parameter int DW = `SPM_RAM_DW
) (
	input wire logic clk_in,
	input wire logic wr_en_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic [DW-1:0] wdata_in,
	output logic [DW-1:0] rdata_out
);
	// =====================================================
	// Storage
	// No reset: contents are undefined until software loads them
	logic [DW-1:0] mem_ff [0:(1<<AW)-1];
	logic [DW-1:0] nxt_mem [0:(1<<AW)-1];
	generate
		if (AW != `SPM_RAM_AW || DW != `SPM_RAM_DW) begin : g_bad_geom
			$error("spm_map_ram: unsupported geometry");
		end
	endgenerate
	genvar gi;
	generate
		for (gi = 0; gi < (1<<AW); gi++) begin : g_word
			always_comb begin
				nxt_mem[gi] = mem_ff[gi];
				if (wr_en_in && addr_in == AW'(gi))
					nxt_mem[gi] = wdata_in;
			end
			always_ff @(posedge clk_in) begin
				mem_ff[gi] <= nxt_mem[gi];
			end
		end
	endgenerate
	assign rdata_out = mem_ff[addr_in];
endmodule
`default_nettype wire

/* File: hdl/spm_mapper.sv */
// Segment page mapper: logical to physical page translation
// =====================================================
`timescale 1ns/10ps
`default_nettype none
`include "spm_cfg.svh"
module spm_mapper (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [23:1] ua_in,
	input wire logic as_n_in,
	input wire logic first_cpu_cycle_set_in,
	input wire logic supervisor_function_code_in,
	input wire logic spio_in,
	input wire logic read_in,
	input wire logic mmu_wr_stb_in,
	input wire logic ctx_wr_in,
	input wire logic [1:0] ctx_data_in,
	input wire logic [11:0] data_in,
	output logic [11:0] data_out,
	output logic [11:0] phys_page_out,
	output logic limit_overflow_out,
	output logic [3:0] seg_type_out,
	output logic mem_space_out,
	output logic io_space_out,
	output logic spio_space_out,
	output logic addr_latch_phase_out,
	output logic context_select_1_out,
	output logic context_select_2_out,
	output logic map_context_bit_1_out,
	output logic map_context_bit_2_out
);
	// =====================================================
	// Address split and register access decode
	spm_pkg::spm_laddr_s laddr;
	spm_pkg::spm_ram_addr_s ram_addr;
	spm_pkg::spm_limit_s limit_word;
	logic mmu_io;
	logic ram_wr;
	logic [11:0] ram_rdata;
	logic [7:0] page_address_bits;
	// Offset bits bypass translation; of them only ua3 is used, to pick the pair member on register access
	assign laddr = ua_in;
	assign page_address_bits = laddr.page;
	assign mmu_io = spio_in && ua_in[`SPM_MMU_SEL_BIT] && !ua_in[`SPM_MMU_NSEL_BIT];
	// No mode check: guarding the map is the operating system's job
	assign ram_wr = mmu_io && !read_in && mmu_wr_stb_in;
	// =====================================================
	// Context latch and phase state
	spm_pkg::spm_ctx_t ctx_ff, nxt_ctx;
	spm_pkg::spm_phase_e phase_ff, nxt_phase;
	logic as_n_q_ff, nxt_as_n_q;
	logic as_release;
	assign as_release = as_n_in && !as_n_q_ff;
	always_comb begin
		nxt_ctx = ctx_ff;
		nxt_as_n_q = as_n_in;
		nxt_phase = phase_ff;
		if (ctx_wr_in)
			nxt_ctx = ctx_data_in;
		case (phase_ff)
			spm_pkg::SPM_PH_ORIGIN: begin
				// Strobe release wins if both land together
				if (first_cpu_cycle_set_in && !as_release)
					nxt_phase = spm_pkg::SPM_PH_LIMIT;
			end
			spm_pkg::SPM_PH_LIMIT: begin
				if (as_release)
					nxt_phase = spm_pkg::SPM_PH_ORIGIN;
			end
			default: nxt_phase = spm_pkg::SPM_PH_LIMIT;
		endcase
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctx_ff <= `SPM_CTX_RST;
			as_n_q_ff <= 1'b1;
			phase_ff <= spm_pkg::SPM_PH_LIMIT;
		end else begin
			ctx_ff <= nxt_ctx;
			as_n_q_ff <= nxt_as_n_q;
			phase_ff <= nxt_phase;
		end
	end
	assign addr_latch_phase_out = (phase_ff == spm_pkg::SPM_PH_ORIGIN);
	assign context_select_1_out = ctx_ff[0];
	assign context_select_2_out = ctx_ff[1];
	// =====================================================
	// RAM address: select, context, segment
	always_comb begin
		ram_addr.seg = laddr.seg;
		if (supervisor_function_code_in && !mmu_io)
			ram_addr.ctx = `SPM_SUPV_CTX;
		else
			ram_addr.ctx = ctx_ff;
		if (mmu_io)
			ram_addr.limit_sel = ua_in[`SPM_PAIR_SEL_BIT];
		else
			ram_addr.limit_sel = !addr_latch_phase_out;
	end
	assign map_context_bit_1_out = ram_addr.ctx[0];
	assign map_context_bit_2_out = ram_addr.ctx[1];
	spm_map_ram #(
		.AW(`SPM_RAM_AW),
		.DW(`SPM_RAM_DW)
	) u_ram (
		.clk_in(clk_in),
		.wr_en_in(ram_wr),
		.addr_in(ram_addr),
		.wdata_in(data_in),
		.rdata_out(ram_rdata)
	);
	assign limit_word = ram_rdata;
	// =====================================================
	// Origin add, limit check, read-back
	// Origin is a page number, so page 0 is physical zero
	logic [11:0] origin_sum;
	logic [8:0] limit_sum;
	logic [11:0] phys_ff, nxt_phys, rd_ff, nxt_rd;
	logic ovf_ff, nxt_ovf;
	logic [3:0] type_ff, nxt_type;
	assign origin_sum = ram_rdata + {`SPM_PAGE_PAD, page_address_bits};
	assign limit_sum = {1'b0, limit_word.size} + {1'b0, page_address_bits};
	always_comb begin
		nxt_phys = phys_ff;
		nxt_ovf = ovf_ff;
		nxt_type = type_ff;
		nxt_rd = rd_ff;
		if (mmu_io) begin
			if (read_in)
				nxt_rd = ram_rdata;
		end else if (addr_latch_phase_out) begin
			nxt_phys = origin_sum;
		end else begin
			nxt_ovf = limit_sum[`SPM_CARRY_BIT];
			nxt_type = limit_word.kind;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			phys_ff <= `SPM_PAGE_RST;
			ovf_ff <= 1'b0;
			type_ff <= `SPM_TYPE_RST;
			rd_ff <= `SPM_DATA_RST;
		end else begin
			phys_ff <= nxt_phys;
			ovf_ff <= nxt_ovf;
			type_ff <= nxt_type;
			rd_ff <= nxt_rd;
		end
	end
	assign phys_page_out = phys_ff;
	assign limit_overflow_out = ovf_ff;
	assign seg_type_out = type_ff;
	assign data_out = rd_ff;
	// Other codes select no space, so no cycle is started
	assign mem_space_out = (type_ff == `SPM_CODE_MAIN);
	assign io_space_out = (type_ff == `SPM_CODE_IO);
	assign spio_space_out = (type_ff == `SPM_CODE_SPIO);
	// =====================================================
	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);
	sequence s_wr_then_rd;
		ram_wr ##1 (mmu_io && read_in && ram_addr == $past(ram_addr));
	endsequence
	property p_phase_set;
		(as_release && !addr_latch_phase_out) |=> addr_latch_phase_out;
	endproperty
	a_phase_set: assert property (p_phase_set) else $error("phase not set");
	property p_phase_clr;
		(addr_latch_phase_out && first_cpu_cycle_set_in && !as_release)
			|=> !addr_latch_phase_out;
	endproperty
	a_phase_clr: assert property (p_phase_clr) else $error("phase not cleared");
	property p_sup_ctx;
		(supervisor_function_code_in && !mmu_io) |-> (ram_addr.ctx == `SPM_SUPV_CTX);
	endproperty
	a_sup_ctx: assert property (p_sup_ctx) else $error("supervisor context");
	property p_user_ctx;
		(ctx_wr_in ##1 !supervisor_function_code_in)
			|-> (ram_addr.ctx == $past(ctx_data_in));
	endproperty
	a_user_ctx: assert property (p_user_ctx) else $error("user context");
	property p_pair_sel;
		mmu_io |-> (ram_addr.limit_sel == ua_in[`SPM_PAIR_SEL_BIT]);
	endproperty
	a_pair_sel: assert property (p_pair_sel) else $error("pair select");
	property p_seg_addr;
		ram_addr.seg == ua_in[`SPM_SEG_HI:`SPM_SEG_LO];
	endproperty
	a_seg_addr: assert property (p_seg_addr) else $error("segment address");
	// Case equality: map words read unknown until software loads them
	property p_origin_sum;
		(addr_latch_phase_out && !mmu_io)
			|=> (phys_page_out === $past(ram_rdata) + {`SPM_PAGE_PAD, $past(page_address_bits)});
	endproperty
	a_origin_sum: assert property (p_origin_sum) else $error("origin sum");
	property p_overflow;
		(!addr_latch_phase_out && !mmu_io)
			|=> (limit_overflow_out === ($past(limit_word.size) > ~$past(page_address_bits)));
	endproperty
	a_overflow: assert property (p_overflow) else $error("limit overflow");
	property p_wr_rd;
		s_wr_then_rd |=> (data_out == $past(data_in, 2));
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("write read-back");
endmodule
`default_nettype wire

/* File: verification/spm_cpu_model.sv */
// Processor core model issuing mapper bus cycles
`timescale 1ns/10ps
`default_nettype none
module spm_cpu_model (
	input wire logic clk_in,
	output logic [23:1] ua_out,
	output logic as_n_out,
	output logic fcs_out,
	output logic sup_out,
	output logic spio_out,
	output logic read_out,
	output logic stb_out,
	output logic ctx_wr_out,
	output logic [1:0] ctx_out,
	output logic [11:0] wd_out
);
	// =====================================================
	// Idle levels at time zero
	initial begin
		{ua_out, fcs_out, sup_out, spio_out, stb_out, ctx_wr_out, ctx_out, wd_out} = '0;
		{as_n_out, read_out} = 2'b11;
	end
	// =====================================================
	// Bus cycles, changed just after the rising edge
	// Register cycle: ua16 low, ua15 high, ua3 picks the pair member
	task automatic reg_cyc(input logic [6:0] seg, input logic sel, input logic wr,
		input logic [11:0] d);
		@(posedge clk_in);
		spio_out <= 1'b1;
		ua_out <= {seg, 8'h40, sel ? 8'h04 : 8'h00};
		read_out <= ~wr;
		stb_out <= wr;
		wd_out <= wr ? d : ~d;
		@(posedge clk_in);
		spio_out <= 1'b0;
		stb_out <= 1'b0;
		read_out <= 1'b1;
		wd_out <= ~wd_out; // Released data never keeps its old value
	endtask
	// Write then read of the same word on the next edge
	task automatic wr_rd(input logic [6:0] seg, input logic sel, input logic [11:0] d);
		@(posedge clk_in);
		spio_out <= 1'b1;
		ua_out <= {seg, 8'h40, sel ? 8'h04 : 8'h00};
		read_out <= 1'b0;
		stb_out <= 1'b1;
		wd_out <= d;
		@(posedge clk_in);
		read_out <= 1'b1;
		stb_out <= 1'b0;
		wd_out <= ~d;
		@(posedge clk_in);
		spio_out <= 1'b0;
	endtask
	task automatic set_ctx(input logic [1:0] c);
		@(posedge clk_in);
		ctx_wr_out <= 1'b1;
		ctx_out <= c;
		@(posedge clk_in);
		ctx_wr_out <= 1'b0;
		ctx_out <= ~c;
	endtask
	task automatic set_sup(input logic s);
		@(posedge clk_in);
		sup_out <= s;
	endtask
	// Strobe release starts the origin phase
	task automatic xlate(input logic [6:0] seg, input logic [7:0] page);
		@(posedge clk_in);
		ua_out <= {seg, page, 8'h5a};
		as_n_out <= 1'b0;
		@(posedge clk_in);
		as_n_out <= 1'b1;
	endtask
	task automatic end_origin();
		@(posedge clk_in);
		fcs_out <= 1'b1;
		@(posedge clk_in);
		fcs_out <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: verification/spm_mapper_test.sv */
// Self-checking bench for the segment page mapper
`timescale 1ns/10ps
`default_nettype none
module spm_mapper_test;
	logic clk_in, rstn_in;
	logic [23:1] ua;
	logic as_n, fcs, sup, spio, rd, stb, cwr;
	logic [1:0] cd;
	logic [11:0] wd, rdata, phys;
	logic ovf, mem, io, sp, phase, cs1, cs2, mc1, mc2;
	logic [3:0] kind;
	int num_errors = 0;
	int n_tests = 0;
	// =====================================================
	// Clock, reset, watchdog
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	initial begin
		rstn_in = 1'b0;
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
	end
	// About a hundred cycles expected; far longer means a hang
	initial begin
		#100us;
		num_errors++;
		report_and_stop();
	end
	spm_cpu_model u_spm_cpu_model (.clk_in(clk_in), .ua_out(ua), .as_n_out(as_n),
		.fcs_out(fcs), .sup_out(sup), .spio_out(spio), .read_out(rd), .stb_out(stb),
		.ctx_wr_out(cwr), .ctx_out(cd), .wd_out(wd));
	spm_mapper u_spm_mapper (.clk_in(clk_in), .rstn_in(rstn_in), .ua_in(ua),
		.as_n_in(as_n), .first_cpu_cycle_set_in(fcs), .supervisor_function_code_in(sup),
		.spio_in(spio), .read_in(rd), .mmu_wr_stb_in(stb), .ctx_wr_in(cwr),
		.ctx_data_in(cd), .data_in(wd), .data_out(rdata), .phys_page_out(phys),
		.limit_overflow_out(ovf), .seg_type_out(kind), .mem_space_out(mem),
		.io_space_out(io), .spio_space_out(sp), .addr_latch_phase_out(phase),
		.context_select_1_out(cs1), .context_select_2_out(cs2),
		.map_context_bit_1_out(mc1), .map_context_bit_2_out(mc2));
	// =====================================================
	// Compare tasks and verdict
	task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk12({11'h000, got}, {11'h000, exp});
	endtask
	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// =====================================================
	// Helpers
	task automatic rd_chk(input logic [6:0] seg, input logic sel, input logic [11:0] e);
		u_spm_cpu_model.reg_cyc(seg, sel, 1'b0, 12'h000);
		#1 chk12(rdata, e);
	endtask
	// Origin sum in one phase, limit carry and space code in the next
	task automatic xl(input logic [6:0] seg, input logic [7:0] pg, input logic [11:0] ep,
		input logic eo, input logic [3:0] ek);
		u_spm_cpu_model.xlate(seg, pg);
		repeat (3) @(posedge clk_in);
		#1 chk1(phase, 1'b1);
		chk12(phys, ep);
		u_spm_cpu_model.end_origin();
		repeat (3) @(posedge clk_in);
		#1 chk1(phase, 1'b0);
		chk1(ovf, eo);
		chk12({8'h00, kind}, {8'h00, ek});
		chk1(mem, ek == 4'h0);
		chk1(io, ek == 4'h1);
		chk1(sp, ek == 4'h2);
		chk12(phys, ep);
	endtask
	// =====================================================
	// Scenarios
	task automatic t_reset();
		#1 chk1(phase, 1'b0);
		chk1(cs1 | cs2 | mc1 | mc2, 1'b0);
	endtask
	// Same segment, two contexts, back-to-back write then read
	task automatic t_regs();
		u_spm_cpu_model.reg_cyc(7'h05, 1'b0, 1'b1, 12'h120);
		u_spm_cpu_model.reg_cyc(7'h05, 1'b1, 1'b1, 12'h1f0);
		u_spm_cpu_model.reg_cyc(7'h06, 1'b0, 1'b1, 12'h7f0);
		u_spm_cpu_model.reg_cyc(7'h06, 1'b1, 1'b1, 12'h200);
		u_spm_cpu_model.set_ctx(2'h2);
		u_spm_cpu_model.wr_rd(7'h05, 1'b0, 12'h3a0);
		#1 chk12(rdata, 12'h3a0);
		rd_chk(7'h05, 1'b0, 12'h3a0);
		u_spm_cpu_model.reg_cyc(7'h05, 1'b1, 1'b1, 12'h020);
		rd_chk(7'h05, 1'b1, 12'h020);
		u_spm_cpu_model.set_ctx(2'h0);
		rd_chk(7'h05, 1'b0, 12'h120);
		rd_chk(7'h05, 1'b1, 12'h1f0);
	endtask
	task automatic t_user();
		u_spm_cpu_model.set_ctx(2'h2);
		@(posedge clk_in);
		#1 chk12({10'h000, cs2, cs1}, 12'h002);
		chk12({10'h000, mc2, mc1}, 12'h002);
		xl(7'h05, 8'h10, 12'h3b0, 1'b0, 4'h0);
		xl(7'h05, 8'he0, 12'h480, 1'b1, 4'h0);
		xl(7'h05, 8'hdf, 12'h47f, 1'b0, 4'h0);
	endtask
	// Supervisor maps context 0, register access keeps the latch
	task automatic t_sup();
		u_spm_cpu_model.set_sup(1'b1);
		@(posedge clk_in);
		#1 chk12({10'h000, mc2, mc1}, 12'h000);
		xl(7'h05, 8'h0f, 12'h12f, 1'b0, 4'h1);
		xl(7'h05, 8'h10, 12'h130, 1'b1, 4'h1);
		xl(7'h06, 8'hff, 12'h8ef, 1'b0, 4'h2);
		rd_chk(7'h05, 1'b0, 12'h3a0);
		u_spm_cpu_model.reg_cyc(7'h07, 1'b0, 1'b1, 12'h0ab);
		u_spm_cpu_model.set_sup(1'b0);
		rd_chk(7'h07, 1'b0, 12'h0ab);
	endtask
	initial begin
		@(posedge rstn_in);
		t_reset();
		t_regs();
		t_user();
		t_sup();
		report_and_stop();
	end
endmodule
`default_nettype wire
